// ==== dv/lsr_lut_store_bench.sv ====
// self-checking bench for the lookup-table ram / shift register block
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t mismatch", $time); end end
module lsr_lut_store_bench
  import lsr_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, shiftMode = 1'b0, wideMode = 1'b1, writeEnable = 1'b0;
  logic inValid, inReady, primaryDataIn, secondaryDataIn;
  logic [LSR_ADDR_W-1:0] inAddr, readAddr = 5'h00;
  logic [LSR_WIDTH-1:0] dataOut, finalStageCascadeOut;
  int num_errors = 0, num_checks = 0, cyc = 0;
  logic fallValid = 1'b0, fallWe = 1'b0;
  logic [LSR_ADDR_W-1:0] fallAddr = 5'h05;
  logic [LSR_WIDTH-1:0] fallData = 2'h3, fallOut;
  always #20 clk = ~clk;
  lsr_lut_store uut(.clk(clk), .rst(rst), .shiftMode(shiftMode), .wideMode(wideMode),
    .inValid(inValid), .inReady(inReady), .inAddr(inAddr), .primaryDataIn(primaryDataIn),
    .secondaryDataIn(secondaryDataIn), .writeEnable(writeEnable), .readAddr(readAddr),
    .dataOut(dataOut), .finalStageCascadeOut(finalStageCascadeOut));
  lsr_user_model user(.clk(clk), .inReady(inReady), .inValid(inValid), .inAddr(inAddr),
    .primaryDataIn(primaryDataIn), .secondaryDataIn(secondaryDataIn));
  // second copy acting on the falling edge
  lsr_lut_store #(.CLK_INVERT(1'b1)) uutFall(.clk(clk), .rst(rst), .shiftMode(shiftMode),
    .wideMode(wideMode), .inValid(fallValid), .inReady(), .inAddr(fallAddr),
    .primaryDataIn(fallData[0]), .secondaryDataIn(fallData[1]), .writeEnable(fallWe),
    .readAddr(fallAddr), .dataOut(fallOut), .finalStageCascadeOut());
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic ram_test();
    writeEnable = 1'b1;
    readAddr = 5'h03;
    user.push(5'h03, 2'h2);
    user.idle();
    step(1);
    `CHK(dataOut, 2'h2)
    user.push(5'h07, 2'h1);
    user.idle();
    step(1);
    readAddr = 5'h07;
    #1 `CHK(dataOut, 2'h1)
    step(1);
    readAddr = 5'h03;
    writeEnable = 1'b0;
    user.push(5'h03, 2'h0);
    user.push(5'h03, 2'h1);
    user.idle();
    step(3);
    `CHK(dataOut, 2'h2)
    `CHK(inReady, 1'b0)
    writeEnable = 1'b1;
    step(2);
    `CHK(dataOut, 2'h1)
    wideMode = 1'b0;
    user.push(5'h03, 2'h2);
    user.idle();
    step(1);
    `CHK(dataOut, 2'h0)
    wideMode = 1'b1;
  endtask
  task automatic fall_test();
    fallValid = 1'b1;
    fallWe = 1'b1;
    step(1);
    fallValid = 1'b0;
    `CHK(fallOut, 2'h0)
    #20 `CHK(fallOut, 2'h3)
    step(1);
    fallWe = 1'b0;
  endtask
  task automatic shift_test();
    shiftMode = 1'b1;
    readAddr = 5'h00;
    for (int i = 0; i < 32; i++) begin
      user.push(5'h00, (i == 0) ? 2'h1 : 2'h2);
    end
    user.idle();
    step(1);
    `CHK(finalStageCascadeOut, 2'h1)
    `CHK(dataOut, 2'h2)
    readAddr = 5'h1f;
    #1 `CHK(dataOut, 2'h1)
    step(1);
    readAddr = 5'h00;
    writeEnable = 1'b0;
    user.push(5'h00, 2'h1);
    user.idle();
    step(3);
    `CHK(finalStageCascadeOut, 2'h1)
    writeEnable = 1'b1;
    step(1);
    `CHK(finalStageCascadeOut, 2'h2)
    `CHK(dataOut, 2'h1)
  endtask
  initial begin
    step(20);
    rst = 1'b0;
    `CHK(finalStageCascadeOut, 2'h0)
    ram_test();
    fall_test();
    shift_test();
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    `CHK(finalStageCascadeOut, 2'h2)
    conclude();
  end
endmodule

// ==== dv/lsr_user_model.sv ====
// user-side logic model that offers words to the block input buffer
`timescale 1ns/10ps
module lsr_user_model
  import lsr_pkg::*;
(
  input wire logic clk,
  input wire logic inReady,
  output logic inValid,
  output logic [LSR_ADDR_W-1:0] inAddr,
  output logic primaryDataIn,
  output logic secondaryDataIn
);
  initial begin
    inValid = 1'b0;
    inAddr = 5'h00;
    {secondaryDataIn, primaryDataIn} = 2'h0;
  end
  // holds the word until an edge samples inReady high
  task automatic push(input logic [LSR_ADDR_W-1:0] a, input logic [1:0] d);
    logic took;
    inValid = 1'b1;
    inAddr = a;
    {secondaryDataIn, primaryDataIn} = d;
    do begin
      took = (inReady === 1'b1);
      @(posedge clk);
      #1;
    end while (!took);
  endtask
  // released lines flip so a stale word is never mistaken for data
  task automatic idle();
    inValid = 1'b0;
    inAddr = ~inAddr;
    {secondaryDataIn, primaryDataIn} = ~{secondaryDataIn, primaryDataIn};
  endtask
endmodule

// ==== src/lsr_lut_store.sv ====
// lookup-table storage used as distributed ram or addressable shift register
//
// Functional notes
// - write enable edge stores data at address
// - written value appears on output after edge
// - no write without enable at edge
// - ram read is combinational from address
// - optional two-bit ram using secondary data
// - enabled shift moves bits deeper, loads stage0
// - shift only when enable high at edge
// - tap valid only with address stable
// - tap read is asynchronous to clock
// - final stage outputs first bit after 32
// - optional second stream shares enable and clock
// - clock edge polarity selectable, rising default
`timescale 1ns/10ps
module lsr_lut_store
  import lsr_pkg::*;
#(
  parameter bit CLK_INVERT = 1'b0,
  parameter logic [LSR_DEPTH-1:0] INIT_PRIMARY = LSR_INIT_DEFAULT,
  parameter logic [LSR_DEPTH-1:0] INIT_SECONDARY = LSR_INIT_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic shiftMode,
  input wire logic wideMode,
  input wire logic inValid,
  output logic inReady,
  input wire logic [LSR_ADDR_W-1:0] inAddr,
  input wire logic primaryDataIn,
  input wire logic secondaryDataIn,
  input wire logic writeEnable,
  input wire logic [LSR_ADDR_W-1:0] readAddr,
  output logic [LSR_WIDTH-1:0] dataOut,
  output logic [LSR_WIDTH-1:0] finalStageCascadeOut
);
  logic actClk;
  typedef logic [LSR_WIDTH-1:0] lsr_mem_t [LSR_DEPTH];
  logic [LSR_ADDR_W+LSR_WIDTH-1:0] fifo [LSR_BUF_DEPTH];
  logic [LSR_BUF_PTR_W-1:0] wrPtr;
  logic [LSR_BUF_PTR_W-1:0] rdPtr;
  logic [LSR_BUF_CNT_W-1:0] count;
  logic [LSR_BUF_CNT_W-1:0] next_count;
  logic push;
  logic pop;
  logic [LSR_ADDR_W-1:0] headAddr;
  logic headPrimary;
  logic headSecondary;
  logic [2*LSR_DEPTH-1:0] memFlat;

  // inverted clock option costs no extra logic in the cell
  assign actClk = clk ^ CLK_INVERT;

  // two-entry buffer in front of the storage; the write enable drains it
  assign push = inValid && inReady;
  assign pop = (count != LSR_BUF_EMPTY) && writeEnable;
  assign {headAddr, headSecondary, headPrimary} = fifo[rdPtr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge actClk or posedge rst) begin
    if (rst) begin
      count <= LSR_BUF_EMPTY;
      inReady <= 1'b1;
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      count <= next_count;
      inReady <= (next_count != LSR_BUF_FULL);
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

  always_ff @(posedge actClk) begin
    if (push) begin
      fifo[wrPtr] <= {inAddr, secondaryDataIn, primaryDataIn};
    end
  end

  // contents come from parameters at configuration, never from reset
  function automatic lsr_mem_t initContents();
    lsr_mem_t m;
    for (int i = 0; i < LSR_DEPTH; i++) begin
      m[i] = {INIT_SECONDARY[i], INIT_PRIMARY[i]};
    end
    return m;
  endfunction
  lsr_mem_t mem = initContents();

  always_ff @(posedge actClk) begin
    if (pop && !shiftMode) begin
      mem[headAddr][LSR_PRIMARY_BIT] <= headPrimary;
      if (wideMode) begin
        mem[headAddr][LSR_SECONDARY_BIT] <= headSecondary;
      end
    end else if (pop && shiftMode) begin
      for (int i = LSR_LAST_STAGE; i > 0; i--) begin
        mem[i][LSR_PRIMARY_BIT] <= mem[i-1][LSR_PRIMARY_BIT];
        if (wideMode) begin
          mem[i][LSR_SECONDARY_BIT] <= mem[i-1][LSR_SECONDARY_BIT];
        end
      end
      mem[0][LSR_PRIMARY_BIT] <= headPrimary;
      if (wideMode) begin
        mem[0][LSR_SECONDARY_BIT] <= headSecondary;
      end
    end
  end

  // read path is a pure lookup, so it follows the address with no edge
  assign dataOut = mem[readAddr];
  assign finalStageCascadeOut = mem[LSR_LAST_STAGE];

  always_comb begin
    for (int i = 0; i < LSR_DEPTH; i++) begin
      memFlat[2*i +: 2] = mem[i];
    end
  end

  // shadow of the primary stream and a saturating shift count for checking
  logic [LSR_DEPTH-1:0] shadow;
  logic [5:0] shiftCount;
  always_ff @(posedge actClk or posedge rst) begin
    if (rst) begin
      shadow <= '0;
      shiftCount <= '0;
    end else if (pop && shiftMode) begin
      shadow <= {shadow[LSR_DEPTH-2:0], headPrimary};
      if (shiftCount != 6'h20) begin
        shiftCount <= shiftCount + 6'h1;
      end
    end else if (pop) begin
      // a ram write may hit the last stage, so the shadow no longer matches it
      shiftCount <= '0;
    end
  end

  property p_ram_write;
    @(posedge actClk) disable iff (rst)
      (pop && !shiftMode) |=> memFlat[2*$past(headAddr)] == $past(headPrimary);
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("ram write lost");

  property p_readback;
    @(posedge actClk) disable iff (rst)
      (pop && !shiftMode && readAddr == headAddr) ##1 $stable(readAddr)
        |-> dataOut[0] == $past(headPrimary);
  endproperty
  a_readback: assert property (p_readback) else $error("no readback");

  property p_no_write;
    @(posedge actClk) disable iff (rst) !pop |=> $stable(memFlat);
  endproperty
  a_no_write: assert property (p_no_write) else $error("store changed");

  function automatic logic [LSR_WIDTH-1:0] wordAt(logic [2*LSR_DEPTH-1:0] flat,
      logic [LSR_ADDR_W-1:0] a);
    return flat[2*a +: 2];
  endfunction

  // with no commit in between, a new address must show the old contents there
  property p_async_read;
    @(posedge actClk) disable iff (rst)
      (!$past(pop) && !$stable(readAddr)) |-> dataOut == wordAt($past(memFlat), readAddr);
  endproperty
  a_async_read: assert property (p_async_read) else $error("bad lookup");

  property p_wide_ram;
    @(posedge actClk) disable iff (rst)
      (pop && !shiftMode && wideMode)
        |=> memFlat[2*$past(headAddr)+1] == $past(headSecondary);
  endproperty
  a_wide_ram: assert property (p_wide_ram) else $error("second bit lost");

  property p_shift;
    @(posedge actClk) disable iff (rst)
      (pop && shiftMode) |=> memFlat[0] == $past(headPrimary)
        && memFlat[2] == $past(memFlat[0]) && memFlat[62] == $past(memFlat[60]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");

  property p_hold;
    @(posedge actClk) disable iff (rst)
      (shiftMode && !writeEnable)[*2] |-> $stable(memFlat);
  endproperty
  a_hold: assert property (p_hold) else $error("shift without enable");

  property p_cascade;
    @(posedge actClk) disable iff (rst)
      (shiftCount == 6'h20) |-> finalStageCascadeOut[0] == shadow[LSR_LAST_STAGE];
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade wrong");

  property p_dual_shift;
    @(posedge actClk) disable iff (rst)
      (pop && shiftMode && wideMode) |=> memFlat[1] == $past(headSecondary)
        && memFlat[63] == $past(memFlat[61]);
  endproperty
  a_dual_shift: assert property (p_dual_shift) else $error("stream two wrong");

  property p_full;
    @(posedge actClk) disable iff (rst) (count == LSR_BUF_FULL) |-> !inReady;
  endproperty
  a_full: assert property (p_full) else $error("ready while full");

  c_ram_write: cover property (@(posedge actClk) disable iff (rst) pop && !shiftMode);
  c_shift32: cover property (@(posedge actClk) disable iff (rst) shiftCount == 6'h20);
  c_full: cover property (@(posedge actClk) disable iff (rst) count == LSR_BUF_FULL);
  c_wide_shift: cover property (@(posedge actClk) disable iff (rst)
    pop && shiftMode && wideMode);
endmodule

// ==== src/lsr_pkg.sv ====
// constants shared by the lookup-table ram / shift register block
package lsr_pkg;
  localparam int LSR_DEPTH = 32;
  localparam int LSR_ADDR_W = 5;
  localparam int LSR_WIDTH = 2;
  localparam int LSR_BUF_DEPTH = 2;
  localparam int LSR_BUF_PTR_W = 1;
  localparam int LSR_BUF_CNT_W = 2;
  localparam int LSR_LAST_STAGE = LSR_DEPTH - 1;
  localparam int LSR_PRIMARY_BIT = 0;
  localparam int LSR_SECONDARY_BIT = 1;
  localparam logic [LSR_BUF_CNT_W-1:0] LSR_BUF_FULL = 2'h2;
  localparam logic [LSR_BUF_CNT_W-1:0] LSR_BUF_EMPTY = 2'h0;
  localparam logic [LSR_DEPTH-1:0] LSR_INIT_DEFAULT = 32'h0000_0000;
endpackage
